// [verilog/mrs_pkg.sv]
// Shared constants, register map and types of the serial slave handler.
package mrs_pkg;
	localparam int CLK_HZ_DEF = 200_000_000;
	localparam int BAUD_W = 20;
	localparam int NBAUD = 10;
	localparam int BAUD_RATE [NBAUD] = '{300, 600, 1200, 2400, 4800, 9600,
		14400, 19200, 28800, 38400};
	localparam logic [3:0] BAUD_DEF = 4'h5;
	// Bus register byte offsets.
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_STAT = 12'h004;
	localparam logic [11:0] A_INT = 12'h008;
	localparam logic [11:0] A_MASK = 12'h00C;
	localparam logic [11:0] A_HOLD = 12'h100;
	localparam logic [11:0] A_HOLD_END = 12'h250;
	// Control fields.
	localparam int F_STN = 0;
	localparam int F_BAUD = 8;
	localparam int F_D7 = 12;
	localparam int F_PAR = 13;
	localparam int F_STOP2 = 15;
	localparam int F_EN = 16;
	localparam logic [31:0] CTRL_RST = 32'h0001_0501;
	// Status fields.
	localparam int F_RXACT = 0;
	localparam int F_BUSY = 1;
	localparam int F_LEXC = 8;
	localparam int F_LLEN = 16;
	// Interrupt bits and parity field codes.
	localparam int INT_W = 4;
	localparam int I_OK = 0;
	localparam int I_EXC = 1;
	localparam int I_DROP = 2;
	localparam int I_WR = 3;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	// Protocol values.
	localparam logic [7:0] FN_RD = 8'h03;
	localparam logic [7:0] FN_WR1 = 8'h06;
	localparam logic [7:0] FN_WRN = 8'h10;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_FN = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_VAL = 8'h03;
	localparam logic [8:0] RW_TOP = 9'h050;
	localparam logic [8:0] RO_BASE = 9'h080;
	localparam logic [8:0] RO_TOP = 9'h083;
	localparam logic [7:0] RO_IDX_OFF = 8'h30;
	localparam logic [7:0] MAX_WORDS = 8'h4F;
	localparam logic [7:0] STN_MIN = 8'h01;
	localparam logic [7:0] STN_MAX = 8'hF7;
	localparam int NREG = 84;
	localparam int BUF_LEN = 50;
	localparam logic [5:0] BUF_FULL = 6'h32;
	localparam logic [5:0] LEN_MIN = 6'h04;
	localparam logic [5:0] LEN_FIX = 6'h08;
	localparam logic [7:0] LEN_WRN_HDR = 8'h09;
	localparam logic [7:0] RSP_EXC = 8'h03;
	localparam logic [7:0] RSP_WR = 8'h06;
	localparam logic [7:0] RSP_RD_HDR = 8'h03;
	localparam logic [6:0] GAP_NUM = 7'h07;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;

	typedef enum logic [4:0] {
		RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
		RX_PAR = 5'b01000, RX_STOP = 5'b10000
	} mrs_rx_e;
	typedef enum logic [3:0] {
		M_IDLE = 4'b0001, M_CHECK = 4'b0010, M_WRITE = 4'b0100,
		M_TX = 4'b1000
	} mrs_main_e;

	function automatic logic [15:0] mrs_crc(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction
endpackage

// [verilog/mrs_slave.sv]
// Serial register-protocol slave with an AHB-Lite control port.
// Operation
// - Characters carry start bit, data, optional even/odd parity, stop bits.
// - Bit rate selectable from 300 to 38400; master uses same rate.
// - Only functions 3, 6 and 16 are executed; others are unsupported.
// - Read query: address, count 1..79; reply byte count, words high first.
// - Single write query: register address, data high, data low, CRC.
// - Multiple write: start, count 1..79, byte count 2..158, data, CRC.
// - Station address configurable 1..247; other addresses are ignored.
// - Any corrupted character discards the whole message silently.
// - A CRC mismatch drops the message without a reply.
// - Illegal values get a five-byte exception reply, function plus 128.
// - Exception reply sends CRC high byte first, then low byte.
// - Unsupported function code answers exception code 1.
// - Register address outside the implemented range answers code 2.
// - Bad data value or write to read-only register answers code 3.
// - Receive buffer holds 50 bytes; longer frames are discarded.
// - Character format configurable 7/8 data bits and 1/2 stop bits.
`timescale 1ns/1ps
`default_nettype none
module mrs_slave #(
	parameter int CLK_HZ = mrs_pkg::CLK_HZ_DEF
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic rxd,
	output logic txd,
	output logic tx_drive,
	output logic irq
);
	import mrs_pkg::*;

	logic [31:0] ctrl;
	logic [INT_W-1:0] int_stat, int_mask, ev;
	logic wr_pend;
	logic [11:0] wr_addr;
	logic [BAUD_W-1:0] div_tab [NBAUD];
	logic [BAUD_W-1:0] bit_div, bit_rld;
	logic [15:0] hold [NREG];
	logic [7:0] rx_buf [BUF_LEN];
	logic [7:0] stn;
	logic [3:0] baud_sel, char_bits, nd;
	logic d7, par_en, par_odd, stop2, en;
	logic [6:0] gap_thr;
	logic rx_meta, rxd_s;
	mrs_rx_e rx_st;
	logic [BAUD_W-1:0] rx_cnt;
	logic [3:0] rx_bit;
	logic [7:0] rx_sh, rx_byte;
	logic rx_par, rx_err, rx_bad, byte_done, frame_end;
	logic [6:0] gap_bits;
	logic [5:0] rx_len;
	logic [15:0] crc_run, crc_p1, crc_p2;
	mrs_main_e st;
	logic [5:0] f_len;
	logic [7:0] r_fn, r_start, r_cnt, r_exc, wr_k, last_exc;
	logic [7:0] tx_idx, rsp_len, tx_byte;
	logic [15:0] tx_crc;
	logic [11:0] tx_shift;
	logic [3:0] tx_left;
	logic [BAUD_W-1:0] tx_cnt;
	logic tx_busy, tx_go, tx_done;
	logic frame_ok, crc_ok, stn_ok;
	logic [7:0] fn, ahi, alo, chi, clo, bc, cnt_eff, chk_exc;
	logic [8:0] last_a;
	logic rng_ok, ro_hit, qty_bad;

	function automatic logic [6:0] reg_idx(input logic [7:0] a);
		return ({1'b0, a} >= RO_BASE) ? 7'(a - RO_IDX_OFF) : a[6:0];
	endfunction

	// Configuration fields.
	assign stn = ctrl[F_STN +: 8];
	assign baud_sel = ctrl[F_BAUD +: 4];
	assign d7 = ctrl[F_D7];
	assign par_en = ctrl[F_PAR +: 2] == PAR_EVEN || ctrl[F_PAR +: 2] == PAR_ODD;
	assign par_odd = ctrl[F_PAR +: 2] == PAR_ODD;
	assign stop2 = ctrl[F_STOP2];
	assign en = ctrl[F_EN];
	assign nd = d7 ? 4'h7 : 4'h8;
	assign char_bits = 4'h2 + nd + {3'h0, par_en} + {3'h0, stop2};
	assign gap_thr = 7'({3'h0, char_bits} * GAP_NUM) >> 1;

	// Bit periods are fixed per selection, so no run-time divider is needed.
	for (genvar gi = 0; gi < NBAUD; gi++) begin : g_div
		assign div_tab[gi] = BAUD_W'(CLK_HZ / BAUD_RATE[gi]);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_div <= BAUD_W'(CLK_HZ / BAUD_RATE[BAUD_DEF]);
		end else if (ce) begin
			bit_div <= (baud_sel < 4'(NBAUD)) ? div_tab[baud_sel] :
				div_tab[BAUD_DEF];
		end
	end

	// A down-counter also spends a cycle on zero, so it loads one less.
	assign bit_rld = bit_div - 1'b1;

	// Bus slave: zero wait states, writes land in the data phase.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
			hrdata <= 32'h0000_0000;
		end else if (ce) begin
			wr_pend <= hsel && htrans[1] && hready && hwrite;
			wr_addr <= haddr[11:0];
			if (hsel && htrans[1] && hready && !hwrite) begin
				hrdata <= 32'h0000_0000;
				if (haddr[31:12] == 20'h00000) begin
					case (haddr[11:0])
						A_CTRL: hrdata <= ctrl;
						A_STAT: begin
							hrdata[F_RXACT] <= rx_st != RX_IDLE || rx_len != 6'h00;
							hrdata[F_BUSY] <= st != M_IDLE;
							hrdata[F_LEXC +: 8] <= last_exc;
							hrdata[F_LLEN +: 6] <= f_len;
						end
						A_INT: hrdata[INT_W-1:0] <= int_stat;
						A_MASK: hrdata[INT_W-1:0] <= int_mask;
						default: begin
							if (haddr[11:0] >= A_HOLD && haddr[11:0] < A_HOLD_END)
								hrdata[15:0] <= hold[7'((haddr[11:0] - A_HOLD) >> 2)];
						end
					endcase
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= CTRL_RST;
			int_mask <= '0;
		end else if (ce && wr_pend) begin
			if (wr_addr == A_CTRL) ctrl <= hwdata;
			if (wr_addr == A_MASK) int_mask <= hwdata[INT_W-1:0];
		end
	end

	// A new event in the clearing cycle survives the write-one clear.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_stat <= '0;
			irq <= 1'b0;
		end else if (ce) begin
			int_stat <= (int_stat & ~((wr_pend && wr_addr == A_INT) ?
				hwdata[INT_W-1:0] : '0)) | ev;
			irq <= |(int_stat & int_mask);
		end
	end

	// Line input synchroniser.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_meta <= 1'b1;
			rxd_s <= 1'b1;
		end else if (ce) begin
			rx_meta <= rxd;
			rxd_s <= rx_meta;
		end
	end

	assign rx_byte = d7 ? {1'b0, rx_sh[7:1]} : rx_sh;
	assign byte_done = rx_st == RX_STOP && rx_cnt == '0 &&
		!(stop2 && rx_bit == 4'h0);
	assign frame_end = rx_st == RX_IDLE && rxd_s && gap_bits == gap_thr &&
		(rx_len != 6'h00 || rx_bad);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_st <= RX_IDLE;
			rx_cnt <= '0;
			rx_bit <= 4'h0;
			rx_sh <= 8'h00;
			rx_par <= 1'b0;
			rx_err <= 1'b0;
			rx_bad <= 1'b0;
			gap_bits <= 7'h00;
			rx_len <= 6'h00;
			crc_run <= CRC_INIT;
			crc_p1 <= CRC_INIT;
			crc_p2 <= CRC_INIT;
		end else if (ce) begin
			if (rx_st != RX_IDLE) rx_cnt <= rx_cnt - 1'b1;
			unique case (rx_st)
				RX_IDLE: begin
					if (!rxd_s) begin
						rx_st <= RX_START;
						rx_cnt <= bit_div >> 1;
						rx_err <= 1'b0;
						rx_par <= par_odd;
					end else if (rx_cnt == '0) begin
						rx_cnt <= bit_rld;
						if (gap_bits < gap_thr) gap_bits <= gap_bits + 1'b1;
					end else begin
						rx_cnt <= rx_cnt - 1'b1;
					end
					if (frame_end) begin
						rx_len <= 6'h00;
						rx_bad <= 1'b0;
						crc_run <= CRC_INIT;
					end
				end
				RX_START: if (rx_cnt == '0) begin
					rx_cnt <= bit_rld;
					rx_bit <= 4'h0;
					rx_st <= rxd_s ? RX_IDLE : RX_DATA;
				end
				RX_DATA: if (rx_cnt == '0) begin
					rx_cnt <= bit_rld;
					rx_sh <= {rxd_s, rx_sh[7:1]};
					rx_par <= rx_par ^ rxd_s;
					rx_bit <= rx_bit + 1'b1;
					if (rx_bit == nd - 1'b1) begin
						rx_bit <= 4'h0;
						rx_st <= par_en ? RX_PAR : RX_STOP;
					end
				end
				RX_PAR: if (rx_cnt == '0) begin
					rx_cnt <= bit_rld;
					if (rx_par != rxd_s) rx_err <= 1'b1;
					rx_st <= RX_STOP;
				end
				RX_STOP: if (rx_cnt == '0) begin
					rx_cnt <= bit_rld;
					rx_bit <= rx_bit + 1'b1;
					if (!rxd_s) rx_err <= 1'b1;
					if (byte_done) begin
						rx_st <= RX_IDLE;
						gap_bits <= 7'h00;
						// Overflow or a bad character poisons the frame.
						if (rx_err || !rxd_s || rx_len == BUF_FULL) begin
							rx_bad <= 1'b1;
						end else begin
							rx_len <= rx_len + 1'b1;
							crc_p2 <= crc_p1;
							crc_p1 <= crc_run;
							crc_run <= mrs_crc(crc_run, rx_byte);
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge hclk) begin
		if (ce && byte_done && rx_len != BUF_FULL) begin
			rx_buf[rx_len] <= rx_byte;
		end
	end

	// Frame acceptance.
	assign crc_ok = rx_len >= LEN_MIN &&
		crc_p2 == {rx_buf[rx_len - 6'h02], rx_buf[rx_len - 6'h01]};
	assign stn_ok = en && stn >= STN_MIN && stn <= STN_MAX &&
		rx_buf[0] == stn;
	assign frame_ok = !rx_bad && crc_ok && stn_ok;

	// Query decode.
	assign fn = rx_buf[1];
	assign ahi = rx_buf[2];
	assign alo = rx_buf[3];
	assign chi = rx_buf[4];
	assign clo = rx_buf[5];
	assign bc = rx_buf[6];
	assign cnt_eff = (fn == FN_WR1) ? 8'h01 : clo;
	assign last_a = {1'b0, alo} + {1'b0, cnt_eff} - 9'h001;
	assign rng_ok = ahi == 8'h00 && ((last_a < RW_TOP) ||
		({1'b0, alo} >= RO_BASE && last_a <= RO_TOP));
	assign ro_hit = last_a >= RO_BASE;
	assign qty_bad = chi != 8'h00 || clo == 8'h00 || clo > MAX_WORDS;

	always_comb begin
		chk_exc = 8'h00;
		unique case (fn)
			FN_RD: begin
				if (f_len != LEN_FIX || qty_bad) chk_exc = EXC_VAL;
				else if (!rng_ok) chk_exc = EXC_ADDR;
			end
			FN_WR1: begin
				if (f_len != LEN_FIX) chk_exc = EXC_VAL;
				else if (!rng_ok) chk_exc = EXC_ADDR;
				else if (ro_hit) chk_exc = EXC_VAL;
			end
			FN_WRN: begin
				if (qty_bad || bc != {clo[6:0], 1'b0} ||
					{2'h0, f_len} != LEN_WRN_HDR + bc) chk_exc = EXC_VAL;
				else if (!rng_ok) chk_exc = EXC_ADDR;
				else if (ro_hit) chk_exc = EXC_VAL;
			end
			default: chk_exc = EXC_FN;
		endcase
	end

	// Response bytes: exception, read data or write echo, then CRC.
	assign tx_busy = tx_left != 4'h0;
	assign tx_go = st == M_TX && !tx_busy && tx_idx < rsp_len + 8'h02;
	assign tx_done = st == M_TX && !tx_busy && tx_idx == rsp_len + 8'h02;

	always_comb begin
		logic [7:0] off;
		logic [15:0] w;
		off = tx_idx - RSP_RD_HDR;
		w = hold[reg_idx(r_start + {1'b0, off[7:1]})];
		tx_byte = rx_buf[tx_idx[5:0]];
		if (tx_idx == rsp_len) tx_byte = tx_crc[15:8];
		else if (tx_idx == rsp_len + 8'h01) tx_byte = tx_crc[7:0];
		else if (r_exc != 8'h00) begin
			if (tx_idx == 8'h01) tx_byte = r_fn | EXC_FLAG;
			else if (tx_idx == 8'h02) tx_byte = r_exc;
		end else if (r_fn == FN_RD) begin
			if (tx_idx == 8'h02) tx_byte = {r_cnt[6:0], 1'b0};
			else if (tx_idx >= RSP_RD_HDR) tx_byte = off[0] ? w[7:0] : w[15:8];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= M_IDLE;
			f_len <= 6'h00;
			r_fn <= 8'h00;
			r_start <= 8'h00;
			r_cnt <= 8'h00;
			r_exc <= 8'h00;
			last_exc <= 8'h00;
			wr_k <= 8'h00;
			tx_idx <= 8'h00;
			rsp_len <= 8'h00;
			tx_crc <= CRC_INIT;
			ev <= '0;
		end else if (ce) begin
			ev <= '0;
			unique case (st)
				M_IDLE: if (frame_end) begin
					f_len <= rx_len;
					if (frame_ok) st <= M_CHECK;
					else if (rx_bad || !crc_ok) ev[I_DROP] <= 1'b1;
				end
				M_CHECK: begin
					r_fn <= fn;
					r_start <= alo;
					r_cnt <= cnt_eff;
					r_exc <= chk_exc;
					last_exc <= chk_exc;
					wr_k <= 8'h00;
					tx_idx <= 8'h00;
					tx_crc <= CRC_INIT;
					if (chk_exc != 8'h00) rsp_len <= RSP_EXC;
					else if (fn == FN_RD) rsp_len <= RSP_RD_HDR + {clo[6:0], 1'b0};
					else rsp_len <= RSP_WR;
					st <= (chk_exc == 8'h00 && fn != FN_RD) ? M_WRITE : M_TX;
				end
				M_WRITE: begin
					wr_k <= wr_k + 8'h01;
					ev[I_WR] <= 1'b1;
					if (wr_k == r_cnt - 8'h01) st <= M_TX;
				end
				M_TX: begin
					if (tx_go) begin
						tx_idx <= tx_idx + 8'h01;
						if (tx_idx < rsp_len) tx_crc <= mrs_crc(tx_crc, tx_byte);
					end
					if (tx_done) begin
						st <= M_IDLE;
						ev[r_exc != 8'h00 ? I_EXC : I_OK] <= 1'b1;
					end
				end
			endcase
		end
	end

	// Holding registers; a serial write wins over a bus write in one cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NREG; i++) hold[i] <= 16'h0000;
		end else if (ce) begin
			if (st == M_WRITE) begin
				if (r_fn == FN_WR1) begin
					hold[reg_idx(r_start)] <= {rx_buf[4], rx_buf[5]};
				end else begin
					hold[reg_idx(r_start + wr_k)] <=
						{rx_buf[6'(8'h07 + {wr_k[6:0], 1'b0})],
						rx_buf[6'(8'h08 + {wr_k[6:0], 1'b0})]};
				end
			end else if (wr_pend && wr_addr >= A_HOLD && wr_addr < A_HOLD_END) begin
				hold[7'((wr_addr - A_HOLD) >> 2)] <= hwdata[15:0];
			end
		end
	end

	// Transmitter: start bit first, then data, parity and stop bits.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txd <= 1'b1;
			tx_shift <= 12'hFFF;
			tx_left <= 4'h0;
			tx_cnt <= '0;
			tx_drive <= 1'b0;
		end else if (ce) begin
			tx_drive <= st == M_TX;
			if (tx_go) begin
				txd <= 1'b0;
				tx_shift <= {4'hF, tx_byte};
				if (d7) tx_shift[7] <= 1'b1;
				if (par_en) tx_shift[nd] <= par_odd ^ (d7 ? ^tx_byte[6:0] : ^tx_byte);
				tx_left <= char_bits;
				tx_cnt <= bit_rld;
			end else if (tx_busy) begin
				tx_cnt <= tx_cnt - 1'b1;
				if (tx_cnt == '0) begin
					tx_cnt <= bit_rld;
					tx_left <= tx_left - 1'b1;
					txd <= (tx_left == 4'h1) ? 1'b1 : tx_shift[0];
					tx_shift <= {1'b1, tx_shift[11:1]};
				end
			end
		end
	end
endmodule
`default_nettype wire

// [tb/mrs_slave_chk.sv]
// Assertions on the slave's bus, line and interrupt pins.
`timescale 1ns/1ps
`default_nettype none
module mrs_slave_chk
	import mrs_pkg::*;
#(
	parameter int CLK_HZ = CLK_HZ_DEF
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic rxd,
	input wire logic txd,
	input wire logic tx_drive,
	input wire logic irq
);
	// Gap of the shortest format in use; longer characters only wait longer.
	localparam int GAP = 35 * (CLK_HZ / 38400);
	int quiet;
	logic mask_wr;
	logic rd_ph;
	logic [3:0] mask;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	assign rd_ph = hsel && htrans[1] && !hwrite && hready;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			quiet <= 0;
		end else begin
			quiet <= !rxd ? 0 : (quiet < GAP ? quiet + 1 : quiet);
		end
	end
	// Shadow of the mask register, seen only through bus writes.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_wr <= 1'h0;
			mask <= 4'h0;
		end else if (ce) begin
			mask_wr <= hsel && htrans[1] && hready && hwrite &&
				haddr[11:0] == A_MASK;
			if (mask_wr) begin
				mask <= hwdata[3:0];
			end
		end
	end
	sequence low_bit_s;
		!txd [*8];
	endsequence
	sequence stop_bit_s;
		$past(txd, 8) && txd;
	endsequence
	line_idle_a: assert property (!tx_drive |-> txd)
		else $error("line low while the driver is off");
	bit_time_a: assert property ($fell(txd) |-> low_bit_s)
		else $error("low bit shorter than a bit time");
	stop_bit_a: assert property ($fell(tx_drive) |-> stop_bit_s)
		else $error("driver released before a full stop bit");
	gap_first_a: assert property ($rose(tx_drive) |-> quiet == GAP)
		else $error("reply started before the line gap ended");
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus not ready or error response");
	rdata_hold_a: assert property (!rd_ph |=> $stable(hrdata))
		else $error("read data changed without a read");
	hole_zero_a: assert property (rd_ph && haddr[11:0] == 12'h040
		|=> hrdata == 32'h0)
		else $error("unmapped word read nonzero");
	irq_masked_a: assert property (mask == 4'h0 && $past(mask) == 4'h0
		|-> !irq)
		else $error("interrupt raised with all events masked");
	reset_quiet_a: assert property ($rose(hresetn)
		|-> txd && !tx_drive && !irq)
		else $error("outputs not idle after reset");
endmodule
`default_nettype wire

// [tb/mrs_master_model.sv]
// Serial line master that sends queries and collects reply bytes.
`timescale 1ns/1ps
`default_nettype none
module mrs_master_model #(
	parameter int DIV = 16
) (
	input wire logic hclk,
	input wire logic txd,
	output logic rxd
);
	logic [7:0] rx_q[$];
	logic [7:0] b;
	logic par = 1'h0;
	logic pb;
	initial rxd = 1'h1;
	// Start bit, eight data bits lowest first, one stop bit.
	// A byte index brk gets a low stop bit to model line corruption.
	task automatic send_frame(input logic [7:0] f[$], input int brk);
		logic [10:0] ch;
		int nb;
		// More than 3.5 idle characters mark the new message.
		repeat (40 * DIV) @(posedge hclk);
		foreach (f[i]) begin
			ch = {1'h1, i != brk, f[i], 1'h0};
			nb = 10;
			// Even parity goes between the data and the stop bit.
			if (par) begin
				ch = {i != brk, ^f[i], f[i], 1'h0};
				nb = 11;
			end
			for (int k = 0; k < nb; k++) begin
				rxd <= ch[k];
				repeat (DIV) @(posedge hclk);
			end
		end
	endtask
	// A low stop bit or a wrong parity bit inverts the stored byte.
	always begin
		@(negedge txd);
		repeat (DIV / 2) @(posedge hclk);
		for (int k = 0; k < 8; k++) begin
			repeat (DIV) @(posedge hclk);
			b[k] = txd;
		end
		if (par) begin
			repeat (DIV) @(posedge hclk);
			pb = txd;
		end
		repeat (DIV) @(posedge hclk);
		rx_q.push_back((txd && (!par || pb == ^b)) ? b : ~b);
	end
endmodule
`default_nettype wire

// [tb/test_modbus_rtu_slave_handler.sv]
// Bench for the serial slave: bus tasks, line master and expected replies.
`timescale 1ns/1ps
`default_nettype none
module test_modbus_rtu_slave_handler;
	import mrs_pkg::*;
	localparam int CLK_HZ = 614400;
	localparam int DIV = CLK_HZ / 38400;
	localparam logic [7:0] STN = STN_MAX;
	logic hclk = 1'h0;
	logic hresetn = 1'h0;
	logic hsel = 1'h0;
	logic hwrite = 1'h0;
	logic ce = 1'h1;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, rxd, txd, tx_drive, irq;
	int bad_count = 0;
	int compares = 0;
	int cycles = 0;
	int regs[NREG];
	logic [31:0] seed = 32'h44D11884;
	logic [31:0] rd;
	logic [15:0] w;
	logic [7:0] q[$];
	logic [7:0] exp[$];
	logic [7:0] ex_fn[4] = '{8'h04, FN_RD, FN_WR1, FN_RD};
	logic [7:0] ex_lo[4] = '{8'h00, 8'h50, 8'h80, 8'h00};
	logic [7:0] ex_n[4] = '{8'h01, 8'h01, 8'h12, 8'h00};
	logic [7:0] ex_code[4] = '{EXC_FN, EXC_ADDR, EXC_VAL, EXC_VAL};
	always #2.5 hclk = ~hclk;
	mrs_slave #(.CLK_HZ(CLK_HZ)) mrs_slave_inst (.hclk(hclk),
		.hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .rxd(rxd), .txd(txd), .tx_drive(tx_drive),
		.irq(irq));
	mrs_master_model #(.DIV(DIV)) master_inst (.hclk(hclk), .txd(txd),
		.rxd(rxd));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [15:0] crc16(input logic [7:0] f[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (f[i]) begin
			c = c ^ {8'h00, f[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
			end
		end
		return c;
	endfunction
	task automatic seal(inout logic [7:0] f[$]);
		logic [15:0] c;
		c = crc16(f);
		f.push_back(c[15:8]);
		f.push_back(c[7:0]);
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] want,
		input string what);
		compares++;
		if (got !== want) begin
			bad_count++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got,
				want);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 100000) begin
			bad_count++;
			$display("mismatch at %0t: run did not finish", $time);
			finish_test();
		end
	end
	// Address phase held until ready, then data phase held until ready.
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'h1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		r = hrdata;
	endtask
	task automatic push_word(input int v);
		exp.push_back(8'(v >> 8));
		exp.push_back(8'(v));
	endtask
	// An empty expectation waits out the whole window for a stray reply.
	task automatic transact(input int brk, input string what);
		int n;
		master_inst.rx_q.delete();
		if (exp.size() > 0) seal(exp);
		master_inst.send_frame(q, brk);
		n = 0;
		while (n < (50 + 12 * exp.size()) * DIV && (exp.size() == 0
			|| master_inst.rx_q.size() < exp.size())) begin
			@(posedge hclk);
			n++;
		end
		repeat (2 * DIV) @(posedge hclk);
		check(master_inst.rx_q.size(), exp.size(), what);
		foreach (exp[i]) begin
			if (i < master_inst.rx_q.size()) begin
				check(master_inst.rx_q[i], exp[i], what);
			end
		end
		$display("test %s done", what);
	endtask
	initial begin
		int k;
		for (int i = 0; i < NREG; i++) regs[i] = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'h1;
		bus(0, A_CTRL, 0, rd);
		check(rd, CTRL_RST, "control reset");
		bus(0, A_MASK, 0, rd);
		check(rd, 32'h0, "mask reset");
		bus(1, 12'h040, 32'hFFFF_FFFF, rd);
		bus(0, 12'h040, 0, rd);
		check(rd, 32'h0, "unmapped word");
		bus(1, A_CTRL, {15'h0, 1'h1, 4'h0, 4'h9, STN}, rd);
		for (int i = 0; i < 4; i++) begin
			k = (i < 2) ? i : 80 + i;
			regs[k] = int'(xs() & 32'hFFFF);
			bus(1, A_HOLD + 12'(4 * k), regs[k], rd);
		end
		bus(1, A_MASK, 32'h1, rd);
		ce <= 1'h0;
		bus(1, A_MASK, 32'hF, rd);
		ce <= 1'h1;
		bus(0, A_MASK, 0, rd);
		check(rd, 32'h1, "mask frozen by clock enable");
		$display("test bus setup done");
		q = {STN, FN_RD, 8'h00, 8'h00, 8'h00, 8'h02};
		seal(q);
		exp = {STN, FN_RD, 8'h04};
		push_word(regs[0]);
		push_word(regs[1]);
		transact(-1, "read low");
		check(irq, 1'h1, "irq after reply");
		bus(0, A_INT, 0, rd);
		check(rd, 32'h1, "reply event");
		bus(1, A_INT, 32'hF, rd);
		repeat (2) @(posedge hclk);
		check(irq, 1'h0, "irq cleared");
		bus(1, A_CTRL, {15'h0, 1'h1, 1'h0, PAR_EVEN, 1'h0, 4'h9, STN},
			rd);
		master_inst.par = 1'h1;
		q = {STN, FN_RD, 8'h00, 8'h00, 8'h00, 8'h02};
		seal(q);
		exp = {STN, FN_RD, 8'h04};
		push_word(regs[0]);
		push_word(regs[1]);
		transact(-1, "read even parity");
		master_inst.par = 1'h0;
		bus(1, A_CTRL, {15'h0, 1'h1, 4'h0, 4'h9, STN}, rd);
		q = {STN, FN_RD, 8'h00, 8'h82, 8'h00, 8'h02};
		seal(q);
		exp = {STN, FN_RD, 8'h04};
		push_word(regs[82]);
		push_word(regs[83]);
		transact(-1, "read upper");
		w = 16'(xs());
		q = {STN, FN_WR1, 8'h00, 8'h4F, w[15:8], w[7:0]};
		exp = q;
		seal(q);
		transact(-1, "write one");
		bus(0, A_HOLD + 12'h13C, 0, rd);
		check(rd, {16'h0, w}, "word 79");
		q = {STN, FN_WRN, 8'h00, 8'h02, 8'h00, 8'h02, 8'h04};
		for (int i = 2; i < 4; i++) begin
			regs[i] = int'(xs() & 32'hFFFF);
			q.push_back(8'(regs[i] >> 8));
			q.push_back(8'(regs[i]));
		end
		seal(q);
		exp = {STN, FN_WRN, 8'h00, 8'h02, 8'h00, 8'h02};
		transact(-1, "write many");
		bus(0, A_HOLD + 12'h00C, 0, rd);
		check(rd, regs[3], "word 3");
		bus(0, A_INT, 0, rd);
		check(rd, 32'h9, "write events");
		bus(1, A_INT, 32'hF, rd);
		for (int i = 0; i < 4; i++) begin
			q = {STN, ex_fn[i], 8'h00, ex_lo[i], 8'h00, ex_n[i]};
			seal(q);
			exp = {STN, ex_fn[i] | EXC_FLAG, ex_code[i]};
			transact(-1, "exception");
		end
		bus(0, A_STAT, 0, rd);
		check(rd & 32'hFF00, 32'h0300, "last exception code");
		q = {STN, FN_RD, 8'h00, 8'h00, 8'h00, 8'h01};
		seal(q);
		q[7] = q[7] ^ 8'h01;
		exp.delete();
		transact(-1, "bad check");
		bus(0, A_INT, 0, rd);
		check(rd & 32'h4, 32'h4, "drop event");
		check(irq, 1'h0, "masked drop");
		q[7] = q[7] ^ 8'h01;
		transact(2, "broken char");
		q = {8'h11, FN_RD, 8'h00, 8'h00, 8'h00, 8'h01};
		seal(q);
		bus(1, A_INT, 32'hF, rd);
		transact(-1, "other station");
		bus(0, A_INT, 0, rd);
		check(rd & 32'h4, 32'h0, "no drop for other station");
		q = {STN, FN_WRN, 8'h00, 8'h00, 8'h00, 8'h15, 8'h2A};
		repeat (42) q.push_back(8'(xs()));
		seal(q);
		transact(-1, "overlong frame");
		finish_test();
	end
endmodule
bind mrs_slave mrs_slave_chk #(.CLK_HZ(CLK_HZ)) chk_inst (.hclk(hclk),
	.hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .rxd(rxd), .txd(txd), .tx_drive(tx_drive),
	.irq(irq));
`default_nettype wire
